// *** hdl/bbx_exec.sv ***
// Branch and bit-set execution core, top level
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bbx_exec #(
  parameter int unsigned PC_W = 21
) (
  // Clock and reset
  input  logic                       CLOCK,
  input  logic                       SYS_RST,
  // Register bus write channels
  input  logic [bbx_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input  logic                       S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  logic [31:0]                S_AXI_WDATA,
  input  logic [3:0]                 S_AXI_WSTRB,
  input  logic                       S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  logic                       S_AXI_BREADY,
  // Register bus read channels
  input  logic [bbx_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input  logic                       S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  logic                       S_AXI_RREADY,
  // Fetch side
  input  logic [15:0]                INSTR,
  input  logic                       INSTR_TWO_WORD,
  output logic [PC_W-1:0]            FETCH_ADDR,
  output logic [3:0]                 PHASE,
  // Status
  input  logic                       ZERO_FLAG,
  // Data file
  output logic [bbx_pkg::FA_W-1:0]   FILE_ADDR,
  output logic                       FILE_RD,
  output logic                       FILE_WR,
  output logic [7:0]                 FILE_WDATA,
  input  logic [7:0]                 FILE_RDATA
);
  if (PC_W < 12 || PC_W > 32) begin : g_bad_pc_w
    $error("PC_W must lie between 12 and 32");
  end

  bbx_cfg_if #(.PC_W(PC_W)) cfg ();

  bbx_pkg::bbx_phase_t         q_r, q_nxt;
  bbx_pkg::bbx_bitop_t         bop;
  bbx_pkg::bbx_jnz_t           jnz;
  bbx_pkg::bbx_rjmp_t          rjmp;
  logic [15:0]                 instr_r;
  logic                        two_r, nop_r, skip_ext_r;
  logic                        jump_r, skip_r;
  logic [1:0]                  flush_cnt_r, flush_nxt;
  logic [7:0]                  data_r;
  logic [PC_W-1:0]             pc_r, pc_nxt;
  logic [PC_W-1:0]             step, off8_x, off11_x;
  logic [PC_W-1:0]             jnz_tgt, rjmp_tgt;
  logic [bbx_pkg::FA_W-1:0]    file_addr_r, map_addr;
  logic                        file_rd_r, file_wr_r;
  logic [7:0]                  file_wdata_r, bit_mask;
  logic                        is_jnz, is_rjmp, is_set, is_tsc, is_tss;
  logic                        bit_op, bit_now, jump_now, skip_now;
  logic                        phase_go, at_q1, at_q2, at_q3, at_q4;

  bbx_axil_regs u_regs (
    .clk           (CLOCK),
    .rst           (SYS_RST),
    .s_axi_awaddr  (S_AXI_AWADDR),
    .s_axi_awvalid (S_AXI_AWVALID),
    .s_axi_awready (S_AXI_AWREADY),
    .s_axi_wdata   (S_AXI_WDATA),
    .s_axi_wstrb   (S_AXI_WSTRB),
    .s_axi_wvalid  (S_AXI_WVALID),
    .s_axi_wready  (S_AXI_WREADY),
    .s_axi_bresp   (S_AXI_BRESP),
    .s_axi_bvalid  (S_AXI_BVALID),
    .s_axi_bready  (S_AXI_BREADY),
    .s_axi_araddr  (S_AXI_ARADDR),
    .s_axi_arvalid (S_AXI_ARVALID),
    .s_axi_arready (S_AXI_ARREADY),
    .s_axi_rdata   (S_AXI_RDATA),
    .s_axi_rresp   (S_AXI_RRESP),
    .s_axi_rvalid  (S_AXI_RVALID),
    .s_axi_rready  (S_AXI_RREADY),
    .cfg           (cfg.regs)
  );

  bbx_addr_map u_map (
    .fad    (bop.fad),
    .acc    (bop.acc),
    .bank   (cfg.bank),
    .ext_en (cfg.ext_en),
    .index  (cfg.index),
    .addr   (map_addr)
  );

  // ************************************************************
  // Decode
  // ************************************************************
  assign bop      = bbx_pkg::bbx_bitop_t'(instr_r);
  assign jnz      = bbx_pkg::bbx_jnz_t'(instr_r);
  assign rjmp     = bbx_pkg::bbx_rjmp_t'(instr_r);
  // A flushed slot decodes as nothing at all
  assign is_jnz   = !nop_r && jnz.op == bbx_pkg::OPC_JNZ;
  assign is_rjmp  = !nop_r && rjmp.op == bbx_pkg::OPC_RJMP;
  assign is_set   = !nop_r && bop.op == bbx_pkg::OPC_SET;
  assign is_tsc   = !nop_r && bop.op == bbx_pkg::OPC_TSC;
  assign is_tss   = !nop_r && bop.op == bbx_pkg::OPC_TSS;
  assign bit_op   = is_set || is_tsc || is_tss;
  assign bit_mask = bbx_pkg::BIT_ONE << bop.bit_idx;
  assign bit_now  = data_r[bop.bit_idx];
  assign jump_now = is_rjmp || (is_jnz && !ZERO_FLAG);
  assign skip_now = (is_tsc && !bit_now) || (is_tss && bit_now);

  // ************************************************************
  // Target arithmetic
  // ************************************************************
  // The counter already points past this word, so no extra +2 here
  assign step     = PC_W'(bbx_pkg::PC_STEP);
  assign off8_x   = {{(PC_W-9){jnz.off[7]}}, jnz.off, 1'b0};
  assign off11_x  = {{(PC_W-12){rjmp.off[10]}}, rjmp.off, 1'b0};
  assign jnz_tgt  = pc_r + off8_x;
  assign rjmp_tgt = pc_r + off11_x;
  assign pc_nxt   = !jump_r ? pc_r + step
                  : is_rjmp ? rjmp_tgt : jnz_tgt;
  // Only a skip extends itself over the second word of its victim
  assign flush_nxt = nop_r ? flush_cnt_r - 2'h1
                             + {1'b0, skip_ext_r && two_r}
                           : {1'b0, jump_r || skip_r};

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  // Halting only at a cycle boundary keeps a read-modify-write whole
  assign phase_go = (q_r != bbx_pkg::Q1) || cfg.run;
  assign at_q1    = phase_go && q_r == bbx_pkg::Q1;
  assign at_q2    = q_r == bbx_pkg::Q2;
  assign at_q3    = q_r == bbx_pkg::Q3;
  assign at_q4    = q_r == bbx_pkg::Q4;

  always_comb begin
    unique case (q_r)
      bbx_pkg::Q1: q_nxt = cfg.run ? bbx_pkg::Q2 : bbx_pkg::Q1;
      bbx_pkg::Q2: q_nxt = bbx_pkg::Q3;
      bbx_pkg::Q3: q_nxt = bbx_pkg::Q4;
      bbx_pkg::Q4: q_nxt = bbx_pkg::Q1;
      default:     q_nxt = bbx_pkg::Q1;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q_r <= bbx_pkg::Q1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ************************************************************
  // Data file read-modify-write
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      file_rd_r   <= 1'b0;
      file_addr_r <= '0;
      data_r      <= '0;
    end else begin
      file_rd_r <= at_q1 && bit_op;
      if (at_q1 && bit_op) begin
        file_addr_r <= map_addr;
      end
      if (at_q2 && bit_op) begin
        data_r <= FILE_RDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      file_wr_r    <= 1'b0;
      file_wdata_r <= '0;
    end else begin
      file_wr_r <= at_q3 && is_set;
      if (at_q3 && is_set) begin
        file_wdata_r <= data_r | bit_mask;
      end
    end
  end

  // ************************************************************
  // Branch, skip and counter update
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      jump_r <= 1'b0;
      skip_r <= 1'b0;
    end else if (at_q3) begin
      jump_r <= jump_now;
      skip_r <= skip_now;
    end else if (at_q4) begin
      jump_r <= 1'b0;
      skip_r <= 1'b0;
    end
  end

  // The first slot after reset is a fill cycle with nothing to execute
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pc_r        <= PC_W'(bbx_pkg::RST_PC);
      instr_r     <= '0;
      two_r       <= 1'b0;
      nop_r       <= 1'b1;
      flush_cnt_r <= bbx_pkg::FLUSH_FILL;
      skip_ext_r  <= 1'b0;
    end else if (at_q4) begin
      pc_r        <= pc_nxt;
      instr_r     <= INSTR;
      two_r       <= INSTR_TWO_WORD;
      flush_cnt_r <= flush_nxt;
      nop_r       <= flush_nxt != 2'h0;
      skip_ext_r  <= skip_r;
    end
  end

  assign cfg.pc     = pc_r;
  assign cfg.stat   = {3'h0, skip_r, jump_r, nop_r, flush_cnt_r};
  assign FETCH_ADDR = pc_r;
  assign PHASE      = q_r;
  assign FILE_ADDR  = file_addr_r;
  assign FILE_RD    = file_rd_r;
  assign FILE_WR    = file_wr_r;
  assign FILE_WDATA = file_wdata_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_jump_commit;
    at_q4 && jump_r;
  endsequence

  sequence s_flushed_slot;
    nop_r && !FILE_RD && !FILE_WR;
  endsequence

  sequence s_rmw(logic [7:0] m);
    FILE_RD ##1 !FILE_RD ##1
      (FILE_WR && FILE_WDATA == ($past(FILE_RDATA, 2) | m));
  endsequence

  jnz_decode_a: assert property (
    at_q3 && !nop_r && jnz.op == bbx_pkg::OPC_JNZ && !ZERO_FLAG
    |=> jump_r)
    else $error("branch_not_zero with zero clear did not jump");

  jnz_fall_thru_a: assert property (
    at_q4 && is_jnz && !jump_r
    |=> pc_r == $past(pc_r) + step && !nop_r && flush_cnt_r == 2'h0)
    else $error("untaken branch did not fall through");

  jnz_target_a: assert property (
    at_q4 && is_jnz && jump_r |=> pc_r == $past(jnz_tgt))
    else $error("branch_not_zero target wrong");

  branch_flush_a: assert property (
    s_jump_commit |=> s_flushed_slot [*4])
    else $error("taken branch second cycle not flushed");

  rjmp_target_a: assert property (
    at_q3 && !nop_r && rjmp.op == bbx_pkg::OPC_RJMP
    ##1 at_q4 |=> pc_r == $past(rjmp_tgt) && nop_r)
    else $error("relative_jump target or flush wrong");

  set_rmw_a: assert property (
    at_q1 && is_set |=> s_rmw(bit_mask))
    else $error("bit set read-modify-write out of step");

  access_bank_a: assert property (
    at_q1 && bit_op && !bop.acc && !(cfg.ext_en
      && bop.fad <= bbx_pkg::IDX_MAX)
    |=> FILE_ADDR[7:0] == $past(bop.fad)
      && FILE_ADDR[11:8] == ($past(bop.fad) < bbx_pkg::ACC_SPLIT
         ? bbx_pkg::ACC_LO_BANK : bbx_pkg::ACC_HI_BANK))
    else $error("access bank address wrong");

  bank_select_a: assert property (
    at_q1 && bit_op && bop.acc
    |=> FILE_ADDR == {$past(cfg.bank), $past(bop.fad)})
    else $error("bank select address wrong");

  indexed_mode_a: assert property (
    at_q1 && bit_op && !bop.acc && cfg.ext_en
      && bop.fad <= bbx_pkg::IDX_MAX
    |=> FILE_ADDR == $past(cfg.index) + 12'($past(bop.fad)))
    else $error("indexed literal offset address wrong");

  skip_two_a: assert property (
    at_q4 && skip_r |=> nop_r && flush_cnt_r == 2'h1
      && pc_r == $past(pc_r) + step)
    else $error("skip did not discard the fetched word");

  skip_three_a: assert property (
    at_q4 && nop_r && skip_ext_r && two_r
    |=> nop_r && flush_cnt_r == 2'h1)
    else $error("skip over two-word instruction not extended");
endmodule

// *** include/bbx_pkg.sv ***
// Shared constants and types of the branch and bit-set execution core
package bbx_pkg;

  // ************************************************************
  // Instruction encodings
  // ************************************************************
  localparam logic [7:0] OPC_JNZ  = 8'he1;
  localparam logic [4:0] OPC_RJMP = 5'h1a;
  localparam logic [3:0] OPC_SET  = 4'h8;
  localparam logic [3:0] OPC_TSC  = 4'hb;
  localparam logic [3:0] OPC_TSS  = 4'ha;

  typedef struct packed {
    logic [3:0] op;
    logic [2:0] bit_idx;
    logic       acc;
    logic [7:0] fad;
  } bbx_bitop_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] off;
  } bbx_jnz_t;

  typedef struct packed {
    logic [4:0]  op;
    logic [10:0] off;
  } bbx_rjmp_t;

  // ************************************************************
  // Addressing, program counter and sequencing
  // ************************************************************
  localparam int unsigned FA_W        = 12;
  localparam logic [7:0]  IDX_MAX     = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK = 4'hf;
  localparam logic [7:0]  BIT_ONE     = 8'h01;
  localparam logic [31:0] PC_STEP     = 32'h2;
  localparam logic [31:0] RST_PC      = 32'h0;
  localparam logic [1:0]  FLUSH_FILL  = 2'h1;

  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } bbx_phase_t;

  // ************************************************************
  // Register bus map
  // ************************************************************
  localparam int unsigned AXI_AW    = 8;
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_BANK  = 8'h04;
  localparam logic [7:0]  REG_INDEX = 8'h08;
  localparam logic [7:0]  REG_PC    = 8'h0c;
  localparam logic [7:0]  REG_STAT  = 8'h10;
  localparam int unsigned CTRL_RUN  = 0;
  localparam int unsigned CTRL_EXT  = 1;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// *** include/bbx_cfg_if.sv ***
// Configuration and status carrier between register slave and core
`timescale 1ns/1ps
interface bbx_cfg_if #(
  parameter int unsigned PC_W = 21
) ();
  logic            run;
  logic            ext_en;
  logic [3:0]      bank;
  logic [11:0]     index;
  logic [PC_W-1:0] pc;
  logic [7:0]      stat;

  modport regs (output run, ext_en, bank, index, input pc, stat);
  modport core (input run, ext_en, bank, index, output pc, stat);
endinterface

// *** hdl/bbx_addr_map.sv ***
// File address resolution for bit-oriented instructions
`timescale 1ns/1ps
module bbx_addr_map (
  // Instruction fields
  input  logic [7:0]  fad,
  input  logic        acc,
  // Configuration
  input  logic [3:0]  bank,
  input  logic        ext_en,
  input  logic [11:0] index,
  // Resolved address
  output logic [11:0] addr
);
  logic        use_idx;
  logic [3:0]  acc_bank;
  logic [11:0] acc_addr;
  logic [11:0] idx_addr;

  // Low access addresses become index-relative in extended mode
  assign use_idx  = !acc && ext_en && (fad <= bbx_pkg::IDX_MAX);
  assign acc_bank = (fad < bbx_pkg::ACC_SPLIT) ? bbx_pkg::ACC_LO_BANK
                                               : bbx_pkg::ACC_HI_BANK;
  assign acc_addr = {acc_bank, fad};
  assign idx_addr = index + 12'(fad);
  assign addr     = use_idx ? idx_addr
                  : acc     ? {bank, fad}
                  : acc_addr;
endmodule

// *** hdl/bbx_axil_regs.sv ***
// AXI4-Lite register slave for the execution core
`timescale 1ns/1ps
module bbx_axil_regs (
  // Clock and reset
  input  logic                       clk,
  input  logic                       rst,
  // Write channels
  input  logic [bbx_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  logic                       s_axi_awvalid,
  output logic                       s_axi_awready,
  input  logic [31:0]                s_axi_wdata,
  input  logic [3:0]                 s_axi_wstrb,
  input  logic                       s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  logic                       s_axi_bready,
  // Read channels
  input  logic [bbx_pkg::AXI_AW-1:0] s_axi_araddr,
  input  logic                       s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  logic                       s_axi_rready,
  // Core side
  bbx_cfg_if.regs                    cfg
);
  logic                       awready_r, wready_r, bvalid_r;
  logic                       arready_r, rvalid_r;
  logic [1:0]                 bresp_r, rresp_r;
  logic [31:0]                rdata_r, wdata_r;
  logic [3:0]                 wstrb_r;
  logic [bbx_pkg::AXI_AW-1:0] aw_addr_r;
  logic                       wr_fire, w_ctrl, w_bank, w_index, w_hit;
  logic                       r_hit;
  logic [31:0]                ctrl_word, cur_word, merged, rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  assign wr_fire   = !awready_r && !wready_r && !bvalid_r;
  assign w_ctrl    = aw_addr_r == bbx_pkg::REG_CTRL;
  assign w_bank    = aw_addr_r == bbx_pkg::REG_BANK;
  assign w_index   = aw_addr_r == bbx_pkg::REG_INDEX;
  // Read-only registers swallow writes but answer OKAY
  assign w_hit     = w_ctrl || w_bank || w_index
                  || aw_addr_r == bbx_pkg::REG_PC
                  || aw_addr_r == bbx_pkg::REG_STAT;
  assign ctrl_word = 32'({cfg.ext_en, cfg.run});
  assign cur_word  = w_ctrl ? ctrl_word
                   : w_bank ? 32'(cfg.bank) : 32'(cfg.index);
  assign merged    = merge(cur_word, wdata_r, wstrb_r);
  assign r_hit     = s_axi_araddr == bbx_pkg::REG_CTRL
                  || s_axi_araddr == bbx_pkg::REG_BANK
                  || s_axi_araddr == bbx_pkg::REG_INDEX
                  || s_axi_araddr == bbx_pkg::REG_PC
                  || s_axi_araddr == bbx_pkg::REG_STAT;
  assign rd_word   = (s_axi_araddr == bbx_pkg::REG_CTRL)  ? ctrl_word
                   : (s_axi_araddr == bbx_pkg::REG_BANK)  ? 32'(cfg.bank)
                   : (s_axi_araddr == bbx_pkg::REG_INDEX) ? 32'(cfg.index)
                   : (s_axi_araddr == bbx_pkg::REG_PC)    ? 32'(cfg.pc)
                   : (s_axi_araddr == bbx_pkg::REG_STAT)  ? 32'(cfg.stat)
                   : 32'h0;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ************************************************************
  // Write path
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= bbx_pkg::RESP_OKAY;
      aw_addr_r <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_hit ? bbx_pkg::RESP_OKAY : bbx_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.run    <= 1'b0;
      cfg.ext_en <= 1'b0;
      cfg.bank   <= bbx_pkg::BANK_RST;
      cfg.index  <= '0;
    end else if (wr_fire) begin
      if (w_ctrl) begin
        cfg.run    <= merged[bbx_pkg::CTRL_RUN];
        cfg.ext_en <= merged[bbx_pkg::CTRL_EXT];
      end
      if (w_bank) begin
        cfg.bank <= 4'(merged);
      end
      if (w_index) begin
        cfg.index <= 12'(merged);
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= bbx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= r_hit ? bbx_pkg::RESP_OKAY : bbx_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end
endmodule

// *** test/bbx_far_model.sv ***
// Far-side model: program memory and data register file
`timescale 1ns/1ps
module bbx_far_model (
  // Fetch side
  input  logic        clk,
  input  logic [20:0] fa,
  output logic [15:0] instr,
  output logic        two_word,
  // Data file
  input  logic [11:0] faddr,
  input  logic        rd,
  input  logic        wr,
  input  logic [7:0]  wdata,
  output logic [7:0]  rdata
);
  logic [15:0] pm [64];
  logic        tw [64];
  logic [7:0]  fd [4096];
  assign instr    = pm[fa[6:1]];
  assign two_word = tw[fa[6:1]];
  // Inverted outside the strobe so a stale value never passes
  assign rdata = rd ? fd[faddr] : ~fd[faddr];
  always @(posedge clk) if (wr) fd[faddr] <= wdata;
endmodule

// *** test/branch_and_bit_set_exec_test.sv ***
// Self-checking bench for the branch and bit-set core
`timescale 1ns/1ps
module branch_and_bit_set_exec_test;
  logic        CLOCK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_RREADY, ZERO_FLAG, S_AXI_AWREADY;
  logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        INSTR_TWO_WORD, FILE_RD, FILE_WR, prev, ext, fop;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, FILE_WDATA, FILE_RDATA;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d, r;
  logic [3:0]  S_AXI_WSTRB, PHASE, bank;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rd_r, wr_b;
  logic [15:0] INSTR, ex;
  logic [20:0] FETCH_ADDR, pc;
  logic [11:0] FILE_ADDR, idx, ea;
  logic [7:0]  mf [4096];
  integer      fail_count = 0, n_tests = 0, seed = 22, fl = 1, cyc = 0, i;
  bbx_exec dut_u (.CLOCK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .INSTR, .INSTR_TWO_WORD,
    .FETCH_ADDR, .PHASE, .ZERO_FLAG, .FILE_ADDR, .FILE_RD, .FILE_WR,
    .FILE_WDATA, .FILE_RDATA);
  bbx_far_model far (.clk(CLOCK), .fa(FETCH_ADDR), .instr(INSTR),
    .two_word(INSTR_TWO_WORD), .faddr(FILE_ADDR), .rd(FILE_RD),
    .wr(FILE_WR), .wdata(FILE_WDATA), .rdata(FILE_RDATA));
  // ********
  // Helpers
  // ********
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    wr_b = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rd_d = S_AXI_RDATA;
    rd_r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  initial begin
    CLOCK = 0;
    forever #5 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  // Only bit operations read the file, and never in a flushed slot
  always @(posedge CLOCK) if (PHASE === 4'h2) begin
    fop = ex[15:12] == 4'h8 || ex[15:13] == 3'h5;
    chk(FILE_RD, fl == 0 && fop);
  end
  // Reference model, stepped at each instruction boundary
  always @(posedge CLOCK) if (PHASE === 4'h8) begin
    chk(FETCH_ADDR, pc);
    ea = ex[8] ? {bank, ex[7:0]} : ex[7:0] >= 8'h60 ? {4'hf, ex[7:0]}
       : ext ? idx + ex[7:0] : {4'h0, ex[7:0]};
    if (fl > 0) begin
      chk(FILE_WR, 0);
      fl = fl - 1;
      pc = pc + 2;
    end else begin
      chk(FILE_WR, ex[15:12] == 4'h8);
      if (ex[15:12] == 4'h8) begin
        mf[ea][ex[11:9]] = 1'b1;
        chk(FILE_ADDR, ea);
        chk(FILE_WDATA, mf[ea]);
      end
      if (ex[15:8] == 8'he1 && ZERO_FLAG === 1'b0) begin
        pc = pc + {{12{ex[7]}}, ex[7:0], 1'b0};
        fl = 1;
      end else if (ex[15:11] == 5'h1a) begin
        pc = pc + {{9{ex[10]}}, ex[10:0], 1'b0};
        fl = 1;
      end else begin
        if (ex[15:13] == 3'h5 && mf[ea][ex[11:9]] == !ex[12])
          fl = 1 + INSTR_TWO_WORD;
        pc = pc + 2;
      end
    end
    ex = INSTR;
    ZERO_FLAG <= $random(seed);
  end
  initial begin
    {SYS_RST, S_AXI_WSTRB, pc, prev} = {1'b1, 4'hf, 22'h0};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, ZERO_FLAG} = 4'h0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = 18'h0;
    S_AXI_WDATA = 32'h0;
    for (i = 0; i < 4096; i++) begin
      mf[i] = $random(seed);
      far.fd[i] = mf[i];
    end
    for (i = 0; i < 64; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0: far.pm[i] = {8'he1, {4{r[7]}}, r[7:4]};
        3'h1: far.pm[i] = {5'h1a, {7{r[7]}}, r[7:4]};
        3'h4: far.pm[i] = {4'ha, r[15:4]};
        3'h5: far.pm[i] = {4'hb, r[15:4]};
        3'h6: far.pm[i] = 16'he17f;
        3'h7: far.pm[i] = 16'hd400;
        default: far.pm[i] = {4'h8, r[15:4]};
      endcase
      prev = r[3] & r[16] & ~prev;
      far.tw[i] = prev;
    end
    repeat (20) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    bank = $random(seed);
    idx = $random(seed);
    wr(bbx_pkg::REG_BANK, {28'h0, bank});
    wr(bbx_pkg::REG_INDEX, {20'h0, idx});
    rd(bbx_pkg::REG_BANK);
    chk(rd_d, {28'h0, bank});
    rd(8'h14);
    chk(rd_r, bbx_pkg::RESP_SLVERR);
    wr(8'h14, 32'h0);
    chk(wr_b, bbx_pkg::RESP_SLVERR);
    ext = 1'b1;
    wr(bbx_pkg::REG_CTRL, 32'h3);
    chk(wr_b, bbx_pkg::RESP_OKAY);
    repeat (3000) @(posedge CLOCK);
    // Halt between instructions so the counter reads back still
    wr(bbx_pkg::REG_CTRL, 32'h0);
    repeat (8) @(posedge CLOCK);
    rd(bbx_pkg::REG_PC);
    chk(rd_d, pc);
    ext = 1'b0;
    wr(bbx_pkg::REG_CTRL, 32'h1);
    repeat (3000) @(posedge CLOCK);
    conclude;
  end
endmodule
